// >>> shared/lrm_pkg.sv
// Summary of operation
// - A 24-bit holding buffer of six 4-bit slices loads only from the exchange bus.
// - The buffer always parallel-loads, capturing the exchange bus on its clock's trailing edge.
// - The buffer output is the only write data, fanned to every location of both sections.
// - Each storage chip holds sixteen 4-bit locations chosen by four binary address lines.
// - All address lines high picks the last location; a selected chip drives its bits.
// - Chip select gates access; write enable high writes, low reads the addressed location.
// - All twenty-four chips share one write enable term and the same four address lines.
// - Group and pad outputs are ORed and inverted per slice; one location per section.
// - B group select enables registers and stack words 8 to 15; pad select right pad.
// - The B section reads and writes whole 24-bit words only.
// - Each A register chip has its own slice select, enabling 4-bit or 16-bit sink writes.
// - A 4-bit or 16-bit source reads the whole word with all six slices selected.
// - The six A left pad chips share one select, so pad words are whole words.
// - Two buffered write enable copies, one per section, come from the single term.
// - A uses seven selects, B two; each decodes only its own section's locations.
// - Low logic nibble sink write asserts address lines one and zero and slice c only.
// - X and Y share one address so both read at once into the adder.
// - Field address and B temporary share one address for the pad relate micro.
package lrm_pkg;

  localparam int LRM_SLICE_W = 4;
  localparam int LRM_SLICES = 6;
  localparam int LRM_DATA_W = LRM_SLICE_W * LRM_SLICES;
  localparam int LRM_ADDR_W = 4;
  localparam int LRM_DEPTH = 16;

  localparam logic [LRM_ADDR_W-1:0] LRM_LAST_ADDR = 4'hf;
  localparam logic [LRM_ADDR_W-1:0] LRM_XY_ADDR = 4'h1;
  localparam logic [LRM_ADDR_W-1:0] LRM_FA_TEMP_ADDR = 4'h4;
  localparam logic [LRM_ADDR_W-1:0] LRM_LC_ADDR = 4'h3;

  localparam logic [LRM_SLICES-1:0] LRM_ALL_SLICES = 6'h3f;
  localparam logic [LRM_SLICES-1:0] LRM_NO_SLICES = 6'h00;
  localparam logic [LRM_SLICES-1:0] LRM_LC_SLICES = 6'h04;
  localparam logic [LRM_SLICES-1:0] LRM_FL_SLICES = 6'h0f;
  localparam int LRM_LC_SLICE_IDX = 2;

  localparam logic [LRM_SLICE_W-1:0] LRM_NIB_ZERO = 4'h0;
  localparam logic [LRM_DATA_W-1:0] LRM_BUF_RESET = 24'h000000;
  // Nothing selected: no chip pulls the wired-OR, so the inverted bus floats to all ones
  localparam logic [LRM_DATA_W-1:0] LRM_IDLE_READ = 24'hffffff;

  typedef enum logic [4:0] {
    LRM_ACC_NONE     = 5'h01,
    LRM_ACC_FULL     = 5'h02,
    LRM_ACC_PARTIAL  = 5'h04,
    LRM_ACC_PAD      = 5'h08,
    LRM_ACC_CONFLICT = 5'h10
  } lrm_access_e;

endpackage

// >>> src/lrm_storage_chip.sv
module lrm_storage_chip (
  input wire logic ref_clk_in,
  input wire logic chip_select_in,
  input wire logic write_enable_in,
  input wire logic [lrm_pkg::LRM_ADDR_W-1:0] addr_in,
  input wire logic [lrm_pkg::LRM_SLICE_W-1:0] data_in,
  output wire logic [lrm_pkg::LRM_SLICE_W-1:0] data_n_out
);

  logic [lrm_pkg::LRM_SLICE_W-1:0] cells [0:lrm_pkg::LRM_DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // Storage is plain data and carries no reset; contents are unknown until written
  always_ff @(posedge ref_clk_in) begin
    if (chip_select_in && write_enable_in) begin
      cells[addr_in] <= data_in;
    end
  end

  // Inverted output, released when deselected so chips can share a wired-OR
  assign data_n_out = chip_select_in ? ~cells[addr_in] : lrm_pkg::LRM_NIB_ZERO;

endmodule // lrm_storage_chip

// >>> src/lrm_local_memory.sv
module lrm_local_memory (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [lrm_pkg::LRM_DATA_W-1:0] main_exchange_bus_in,
  input wire logic holding_buffer_clock_in,
  input wire logic [lrm_pkg::LRM_ADDR_W-1:0] lm_addr_in,
  input wire logic memory_write_enable_in,
  input wire logic [lrm_pkg::LRM_SLICES-1:0] a_slice_selects_in,
  input wire logic a_pad_select_in,
  input wire logic b_group_select_in,
  input wire logic b_pad_select_in,
  output wire logic [lrm_pkg::LRM_DATA_W-1:0] a_read_bus_out,
  output wire logic [lrm_pkg::LRM_DATA_W-1:0] b_read_bus_out,
  output wire logic [lrm_pkg::LRM_DATA_W-1:0] write_holding_buffer_out,
  output wire logic [1:0] section_write_enables_out,
  output logic a_select_conflict_out,
  output logic b_select_conflict_out,
  output logic lc_sink_write_out,
  output logic xy_pair_read_out,
  output logic fa_temp_pair_read_out,
  output lrm_pkg::lrm_access_e a_access_kind_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic lrm_pkg::lrm_access_e classify_a(
    input logic [lrm_pkg::LRM_SLICES-1:0] slices,
    input logic pad
  );
    lrm_pkg::lrm_access_e kind;
    kind = lrm_pkg::LRM_ACC_NONE;
    if (pad && (slices != lrm_pkg::LRM_NO_SLICES)) begin
      kind = lrm_pkg::LRM_ACC_CONFLICT;
    end else if (pad) begin
      kind = lrm_pkg::LRM_ACC_PAD;
    end else if (slices == lrm_pkg::LRM_ALL_SLICES) begin
      kind = lrm_pkg::LRM_ACC_FULL;
    end else if (slices != lrm_pkg::LRM_NO_SLICES) begin
      kind = lrm_pkg::LRM_ACC_PARTIAL;
    end
    return kind;
  endfunction

  // True when the A group is driven as a whole word and B group alongside it
  function automatic logic pair_read(
    input logic [lrm_pkg::LRM_ADDR_W-1:0] addr,
    input logic [lrm_pkg::LRM_ADDR_W-1:0] want,
    input logic [lrm_pkg::LRM_SLICES-1:0] slices,
    input logic a_pad,
    input logic b_grp,
    input logic b_pad,
    input logic we
  );
    return (addr == want) && (slices == lrm_pkg::LRM_ALL_SLICES) && !a_pad && b_grp && !b_pad && !we;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Holding buffer strobe: the trailing edge of the buffer clock loads it

  logic buf_clk_r;
  logic buf_load;
  logic [lrm_pkg::LRM_DATA_W-1:0] hold_buf_r;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_clk_r <= 1'b0;
    end else begin
      buf_clk_r <= holding_buffer_clock_in;
    end
  end

  assign buf_load = buf_clk_r && !holding_buffer_clock_in;

  assign write_holding_buffer_out = hold_buf_r;

  // One write enable term feeds both sections; each copy drives half the chips
  assign section_write_enables_out = {memory_write_enable_in, memory_write_enable_in};

  ////////////////////////////////////////////////////////////////////////////
  // Six bit slices: buffer nibble plus four storage chips each

  genvar s;
  generate
    for (s = 0; s < lrm_pkg::LRM_SLICES; s++) begin : g_slice
      logic [lrm_pkg::LRM_SLICE_W-1:0] a_grp_n;
      logic [lrm_pkg::LRM_SLICE_W-1:0] a_pad_n;
      logic [lrm_pkg::LRM_SLICE_W-1:0] b_grp_n;
      logic [lrm_pkg::LRM_SLICE_W-1:0] b_pad_n;
      logic [lrm_pkg::LRM_SLICE_W-1:0] nib_r;

      assign hold_buf_r[s*lrm_pkg::LRM_SLICE_W +: lrm_pkg::LRM_SLICE_W] = nib_r;

      // Mode control is tied to parallel load, so the nibble only ever follows the exchange bus
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          nib_r <= lrm_pkg::LRM_NIB_ZERO;
        end else if (buf_load) begin
          nib_r <= main_exchange_bus_in[s*lrm_pkg::LRM_SLICE_W +: lrm_pkg::LRM_SLICE_W];
        end
      end

      // A registers and stack: per-slice select allows nibble and 16-bit sinks
      lrm_storage_chip u_a_grp (
        .ref_clk_in(ref_clk_in),
        .chip_select_in(a_slice_selects_in[s]),
        .write_enable_in(section_write_enables_out[0]),
        .addr_in(lm_addr_in),
        .data_in(nib_r),
        .data_n_out(a_grp_n)
      );

      // A left pad: one shared select, whole words only
      lrm_storage_chip u_a_pad (
        .ref_clk_in(ref_clk_in),
        .chip_select_in(a_pad_select_in),
        .write_enable_in(section_write_enables_out[0]),
        .addr_in(lm_addr_in),
        .data_in(nib_r),
        .data_n_out(a_pad_n)
      );

      // B registers and stack words 8 to 15
      lrm_storage_chip u_b_grp (
        .ref_clk_in(ref_clk_in),
        .chip_select_in(b_group_select_in),
        .write_enable_in(section_write_enables_out[1]),
        .addr_in(lm_addr_in),
        .data_in(nib_r),
        .data_n_out(b_grp_n)
      );

      // B right pad
      lrm_storage_chip u_b_pad (
        .ref_clk_in(ref_clk_in),
        .chip_select_in(b_pad_select_in),
        .write_enable_in(section_write_enables_out[1]),
        .addr_in(lm_addr_in),
        .data_in(nib_r),
        .data_n_out(b_pad_n)
      );

      assign a_read_bus_out[s*lrm_pkg::LRM_SLICE_W +: lrm_pkg::LRM_SLICE_W] = ~(a_grp_n | a_pad_n);
      assign b_read_bus_out[s*lrm_pkg::LRM_SLICE_W +: lrm_pkg::LRM_SLICE_W] = ~(b_grp_n | b_pad_n);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Select sanity: two locations on one wired-OR would merge their data

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      a_select_conflict_out <= 1'b0;
      b_select_conflict_out <= 1'b0;
    end else begin
      a_select_conflict_out <= a_pad_select_in && (a_slice_selects_in != lrm_pkg::LRM_NO_SLICES);
      b_select_conflict_out <= b_pad_select_in && b_group_select_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A access classification, one-hot

  lrm_pkg::lrm_access_e a_kind_r;
  lrm_pkg::lrm_access_e a_kind_nxt;

  always_comb begin
    a_kind_nxt = classify_a(a_slice_selects_in, a_pad_select_in);
    case (a_kind_nxt)
      lrm_pkg::LRM_ACC_NONE: a_kind_nxt = lrm_pkg::LRM_ACC_NONE;
      lrm_pkg::LRM_ACC_FULL: a_kind_nxt = lrm_pkg::LRM_ACC_FULL;
      // A partial read is not a legal source form; report it as a conflict
      lrm_pkg::LRM_ACC_PARTIAL: begin
        a_kind_nxt = memory_write_enable_in ? lrm_pkg::LRM_ACC_PARTIAL : lrm_pkg::LRM_ACC_CONFLICT;
      end
      lrm_pkg::LRM_ACC_PAD: a_kind_nxt = lrm_pkg::LRM_ACC_PAD;
      lrm_pkg::LRM_ACC_CONFLICT: a_kind_nxt = lrm_pkg::LRM_ACC_CONFLICT;
      default: a_kind_nxt = lrm_pkg::LRM_ACC_NONE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      a_kind_r <= lrm_pkg::LRM_ACC_NONE;
    end else begin
      a_kind_r <= a_kind_nxt;
    end
  end

  assign a_access_kind_out = a_kind_r;

  ////////////////////////////////////////////////////////////////////////////
  // Recognised micro patterns, reported one cycle after they occur

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lc_sink_write_out <= 1'b0;
    end else begin
      lc_sink_write_out <= memory_write_enable_in && (lm_addr_in == lrm_pkg::LRM_LC_ADDR)
        && (a_slice_selects_in == lrm_pkg::LRM_LC_SLICES) && !a_pad_select_in
        && !b_group_select_in && !b_pad_select_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      xy_pair_read_out <= 1'b0;
      fa_temp_pair_read_out <= 1'b0;
    end else begin
      xy_pair_read_out <= pair_read(lm_addr_in, lrm_pkg::LRM_XY_ADDR, a_slice_selects_in,
        a_pad_select_in, b_group_select_in, b_pad_select_in, memory_write_enable_in);
      fa_temp_pair_read_out <= pair_read(lm_addr_in, lrm_pkg::LRM_FA_TEMP_ADDR, a_slice_selects_in,
        a_pad_select_in, b_group_select_in, b_pad_select_in, memory_write_enable_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic a_full_wr;
  logic a_full_rd;
  logic a_pad_wr;
  logic a_pad_rd;
  logic b_grp_wr;
  logic b_grp_rd;

  assign a_full_wr = memory_write_enable_in && (a_slice_selects_in == lrm_pkg::LRM_ALL_SLICES) && !a_pad_select_in;
  assign a_full_rd = !memory_write_enable_in && (a_slice_selects_in == lrm_pkg::LRM_ALL_SLICES) && !a_pad_select_in;
  assign a_pad_wr = memory_write_enable_in && a_pad_select_in && (a_slice_selects_in == lrm_pkg::LRM_NO_SLICES);
  assign a_pad_rd = !memory_write_enable_in && a_pad_select_in && (a_slice_selects_in == lrm_pkg::LRM_NO_SLICES);
  assign b_grp_wr = memory_write_enable_in && b_group_select_in && !b_pad_select_in;
  assign b_grp_rd = !memory_write_enable_in && b_group_select_in && !b_pad_select_in;

  chk_buffer_capture: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (holding_buffer_clock_in ##1 !holding_buffer_clock_in) |=> write_holding_buffer_out == $past(main_exchange_bus_in)
  ) else $error("holding buffer missed the exchange bus on trailing edge");

  chk_buffer_holds: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !(buf_clk_r && !holding_buffer_clock_in) |=> $stable(write_holding_buffer_out)
  ) else $error("holding buffer changed without a trailing edge");

  chk_a_word_readback: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (a_full_wr ##1 (a_full_rd && lm_addr_in == $past(lm_addr_in)))
      |-> a_read_bus_out == $past(write_holding_buffer_out)
  ) else $error("A word read back differs from buffer written");

  chk_b_last_location: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    ((b_grp_wr && lm_addr_in == lrm_pkg::LRM_LAST_ADDR) ##1 (b_grp_rd && lm_addr_in == lrm_pkg::LRM_LAST_ADDR))
      |-> b_read_bus_out == $past(write_holding_buffer_out)
  ) else $error("B last location read back wrong");

  chk_a_pad_word: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (a_pad_wr ##1 (a_pad_rd && lm_addr_in == $past(lm_addr_in)))
      |-> a_read_bus_out == $past(write_holding_buffer_out)
  ) else $error("A pad word read back wrong");

  chk_lc_partial: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (a_full_rd ##1 (memory_write_enable_in && a_slice_selects_in == lrm_pkg::LRM_LC_SLICES && !a_pad_select_in
      && lm_addr_in == $past(lm_addr_in)) ##1 (a_full_rd && lm_addr_in == $past(lm_addr_in)))
      |-> (a_read_bus_out[lrm_pkg::LRM_LC_SLICE_IDX*lrm_pkg::LRM_SLICE_W +: lrm_pkg::LRM_SLICE_W]
        == $past(write_holding_buffer_out[lrm_pkg::LRM_LC_SLICE_IDX*lrm_pkg::LRM_SLICE_W +: lrm_pkg::LRM_SLICE_W]))
        && (a_read_bus_out[lrm_pkg::LRM_LC_SLICE_IDX*lrm_pkg::LRM_SLICE_W-1:0]
          == $past(a_read_bus_out[lrm_pkg::LRM_LC_SLICE_IDX*lrm_pkg::LRM_SLICE_W-1:0], 2))
  ) else $error("nibble sink write disturbed other slices");

  chk_read_stable: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (!section_write_enables_out[0] && !section_write_enables_out[1]) ##1
      ($stable(lm_addr_in) && $stable(a_slice_selects_in) && $stable(a_pad_select_in)
        && $stable(b_group_select_in) && $stable(b_pad_select_in))
      |-> $stable(a_read_bus_out) && $stable(b_read_bus_out)
  ) else $error("read disturbed stored contents");

  chk_idle_bus: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (a_slice_selects_in == lrm_pkg::LRM_NO_SLICES && !a_pad_select_in) |-> a_read_bus_out == lrm_pkg::LRM_IDLE_READ
  ) else $error("A read bus driven with nothing selected");

  chk_lc_pattern: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    lc_sink_write_out |-> $past(lm_addr_in) == lrm_pkg::LRM_LC_ADDR && $past(memory_write_enable_in)
      && $past(a_slice_selects_in) == lrm_pkg::LRM_LC_SLICES
  ) else $error("nibble sink flag without its pattern");

  chk_xy_flag: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (a_full_rd && b_grp_rd && lm_addr_in == lrm_pkg::LRM_XY_ADDR) |=> xy_pair_read_out
  ) else $error("paired operand read not flagged");

  chk_conflict: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (b_group_select_in && b_pad_select_in) |=> b_select_conflict_out && (a_access_kind_out != lrm_pkg::LRM_ACC_NONE
      || !$past(a_slice_selects_in != lrm_pkg::LRM_NO_SLICES || a_pad_select_in))
  ) else $error("B double select not flagged");

  cov_buffer_load: cover property (
    @(posedge ref_clk_in) disable iff (rst_in) buf_load ##2 a_full_wr
  );

  cov_lc_write: cover property (
    @(posedge ref_clk_in) disable iff (rst_in) lc_sink_write_out
  );

  cov_xy_read: cover property (
    @(posedge ref_clk_in) disable iff (rst_in) xy_pair_read_out
  );

  cov_fa_temp: cover property (
    @(posedge ref_clk_in) disable iff (rst_in) fa_temp_pair_read_out
  );

endmodule // lrm_local_memory

// >>> test/lrm_datapath_model.sv
module lrm_datapath_model (
  input wire logic ref_clk_in,
  output logic [lrm_pkg::LRM_DATA_W-1:0] main_exchange_bus_out,
  output logic holding_buffer_clock_out,
  output logic [lrm_pkg::LRM_ADDR_W-1:0] lm_addr_out,
  output logic memory_write_enable_out,
  output logic [lrm_pkg::LRM_SLICES-1:0] a_slice_selects_out,
  output logic a_pad_select_out,
  output logic b_group_select_out,
  output logic b_pad_select_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    main_exchange_bus_out = 24'h000000;
    holding_buffer_clock_out = 1'b0;
    lm_addr_out = 4'h0;
    memory_write_enable_out = 1'b0;
    a_slice_selects_out = 6'h00;
    a_pad_select_out = 1'b0;
    b_group_select_out = 1'b0;
    b_pad_select_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe high one cycle, then low with the word on the bus; the bus is
  // scrambled afterwards so a late capture cannot pass by accident
  task automatic load_buffer(input logic [lrm_pkg::LRM_DATA_W-1:0] d);
    @(posedge ref_clk_in);
    holding_buffer_clock_out <= 1'b1;
    @(posedge ref_clk_in);
    holding_buffer_clock_out <= 1'b0;
    main_exchange_bus_out <= d;
    @(posedge ref_clk_in);
    main_exchange_bus_out <= ~d;
  endtask

  task automatic drive(input logic w, input logic [3:0] a, input logic [5:0] s, input logic ap, input logic bg,
                       input logic bp);
    @(posedge ref_clk_in);
    memory_write_enable_out <= w;
    lm_addr_out <= a;
    a_slice_selects_out <= s;
    a_pad_select_out <= ap;
    b_group_select_out <= bg;
    b_pad_select_out <= bp;
  endtask
endmodule // lrm_datapath_model

// >>> test/tb_local_register_memory.sv
module tb_local_register_memory;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [23:0] bus;
  logic strobe, we, ap, bg, bp;
  logic [3:0] addr;
  logic [5:0] sl;
  logic [23:0] a_rd, b_rd, buf_q;
  logic [1:0] sec_we;
  logic a_cf, b_cf, lc_f, xy_f, fa_f;
  lrm_pkg::lrm_access_e kind;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  lrm_datapath_model i_dp (.ref_clk_in(ref_clk_in), .main_exchange_bus_out(bus), .holding_buffer_clock_out(strobe),
    .lm_addr_out(addr), .memory_write_enable_out(we), .a_slice_selects_out(sl), .a_pad_select_out(ap),
    .b_group_select_out(bg), .b_pad_select_out(bp));

  lrm_local_memory i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .main_exchange_bus_in(bus),
    .holding_buffer_clock_in(strobe), .lm_addr_in(addr), .memory_write_enable_in(we), .a_slice_selects_in(sl),
    .a_pad_select_in(ap), .b_group_select_in(bg), .b_pad_select_in(bp), .a_read_bus_out(a_rd),
    .b_read_bus_out(b_rd), .write_holding_buffer_out(buf_q), .section_write_enables_out(sec_we),
    .a_select_conflict_out(a_cf), .b_select_conflict_out(b_cf), .lc_sink_write_out(lc_f),
    .xy_pair_read_out(xy_f), .fa_temp_pair_read_out(fa_f), .a_access_kind_out(kind));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Returns just after the write edge with the same selects held as a read
  task automatic wr(input logic [3:0] a, input logic [5:0] s, input logic p, input logic g, input logic q,
                    input logic [23:0] d);
    i_dp.load_buffer(d);
    i_dp.drive(1'b1, a, s, p, g, q);
    #1;
    check("write_enable_copies", 24'(sec_we), 24'h000003);
    i_dp.drive(1'b0, a, s, p, g, q);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [5:0] s, input logic p, input logic g, input logic q);
    i_dp.drive(1'b0, a, s, p, g, q);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("buffer_reset", buf_q, 24'h000000);
    check("kind_reset", 24'(kind), 24'(lrm_pkg::LRM_ACC_NONE));
    check("a_idle", a_rd, 24'hffffff);
    check("b_idle", b_rd, 24'hffffff);
    check("read_enables", 24'(sec_we), 24'h000000);
  endtask

  task automatic t_buffer;
    i_dp.load_buffer(24'h5a3c96);
    #1;
    check("buffer_load", buf_q, 24'h5a3c96);
    repeat (3) @(posedge ref_clk_in);
    #1;
    check("buffer_hold", buf_q, 24'h5a3c96);
  endtask

  task automatic t_full;
    wr(4'hf, 6'h3f, 1'b0, 1'b0, 1'b0, 24'ha1b2c3);
    wr(4'hf, 6'h00, 1'b0, 1'b1, 1'b0, 24'h4d5e6f);
    wr(4'h0, 6'h3f, 1'b0, 1'b0, 1'b0, 24'h13579b);
    wr(4'h0, 6'h00, 1'b0, 1'b1, 1'b0, 24'h2468ac);
    rd(4'hf, 6'h3f, 1'b0, 1'b1, 1'b0);
    check("a_last", a_rd, 24'ha1b2c3);
    check("b_last", b_rd, 24'h4d5e6f);
    rd(4'h0, 6'h3f, 1'b0, 1'b1, 1'b0);
    check("a_first", a_rd, 24'h13579b);
    check("b_first", b_rd, 24'h2468ac);
    wr(4'h0, 6'h00, 1'b0, 1'b0, 1'b0, 24'h111111);
    rd(4'h0, 6'h3f, 1'b0, 1'b1, 1'b0);
    check("a_unselected_write", a_rd, 24'h13579b);
    check("b_unselected_write", b_rd, 24'h2468ac);
  endtask

  task automatic t_pads;
    wr(4'h2, 6'h00, 1'b1, 1'b0, 1'b0, 24'h0badf0);
    wr(4'h2, 6'h00, 1'b0, 1'b0, 1'b1, 24'hc0ffee);
    wr(4'h2, 6'h3f, 1'b0, 1'b1, 1'b0, 24'h777777);
    rd(4'h2, 6'h00, 1'b1, 1'b0, 1'b1);
    check("a_pad", a_rd, 24'h0badf0);
    check("b_pad", b_rd, 24'hc0ffee);
    rd(4'h2, 6'h3f, 1'b0, 1'b1, 1'b0);
    check("a_group", a_rd, 24'h777777);
    check("b_group", b_rd, 24'h777777);
  endtask

  task automatic t_partial;
    wr(lrm_pkg::LRM_LC_ADDR, 6'h3f, 1'b0, 1'b0, 1'b0, 24'h123456);
    // Nibble sink write followed at once by a whole-word source read of the same word
    i_dp.load_buffer(24'habcdef);
    i_dp.drive(1'b1, lrm_pkg::LRM_LC_ADDR, lrm_pkg::LRM_LC_SLICES, 1'b0, 1'b0, 1'b0);
    i_dp.drive(1'b0, lrm_pkg::LRM_LC_ADDR, 6'h3f, 1'b0, 1'b0, 1'b0);
    #1;
    check("lc_flag", 24'(lc_f), 24'h000001);
    check("kind_partial", 24'(kind), 24'(lrm_pkg::LRM_ACC_PARTIAL));
    check("lc_merged", a_rd, 24'h123d56);
    rd(lrm_pkg::LRM_LC_ADDR, lrm_pkg::LRM_LC_SLICES, 1'b0, 1'b0, 1'b0);
    check("slice_read", a_rd, 24'hfffdff);
    @(posedge ref_clk_in);
    #1;
    check("kind_slice_read", 24'(kind), 24'(lrm_pkg::LRM_ACC_CONFLICT));
    wr(lrm_pkg::LRM_LC_ADDR, lrm_pkg::LRM_FL_SLICES, 1'b0, 1'b0, 1'b0, 24'h987654);
    check("lc_flag_16", 24'(lc_f), 24'h000000);
    rd(lrm_pkg::LRM_LC_ADDR, 6'h3f, 1'b0, 1'b0, 1'b0);
    check("fl_merged", a_rd, 24'h127654);
  endtask

  // Both operand pairs: the X/Y address and the field/temporary address
  task automatic t_pairs;
    logic [3:0] pa [2];
    pa[0] = lrm_pkg::LRM_XY_ADDR;
    pa[1] = lrm_pkg::LRM_FA_TEMP_ADDR;
    for (int i = 0; i < 2; i++) begin
      wr(pa[i], 6'h3f, 1'b0, 1'b0, 1'b0, 24'h600d00 + 24'(i));
      wr(pa[i], 6'h00, 1'b0, 1'b1, 1'b0, 24'h0ff100 + 24'(i));
      rd(pa[i], 6'h3f, 1'b0, 1'b1, 1'b0);
      check("pair_a", a_rd, 24'h600d00 + 24'(i));
      check("pair_b", b_rd, 24'h0ff100 + 24'(i));
      @(posedge ref_clk_in);
      #1;
      check("xy_flag", 24'(xy_f), 24'(i == 0));
      check("fa_flag", 24'(fa_f), 24'(i == 1));
    end
  endtask

  task automatic t_conflict;
    wr(4'h6, 6'h00, 1'b0, 1'b1, 1'b0, 24'hf0f0f0);
    wr(4'h6, 6'h00, 1'b0, 1'b0, 1'b1, 24'h3c3c3c);
    wr(4'h6, 6'h3f, 1'b0, 1'b0, 1'b0, 24'hff00ff);
    wr(4'h6, 6'h00, 1'b1, 1'b0, 1'b0, 24'h0f0f0f);
    rd(4'h6, 6'h3f, 1'b1, 1'b1, 1'b1);
    check("a_wired_or", a_rd, 24'h0f000f);
    check("b_wired_or", b_rd, 24'h303030);
    @(posedge ref_clk_in);
    #1;
    check("a_conflict", 24'(a_cf), 24'h000001);
    check("b_conflict", 24'(b_cf), 24'h000001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Ceiling is over twenty times the expected run so a slow design is not cut off
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict;
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_buffer;
    t_full;
    t_pads;
    t_partial;
    t_pairs;
    t_conflict;
    // Let the last registered flags and their checks settle before ending
    repeat (2) @(posedge ref_clk_in);
    print_verdict;
  end
endmodule // tb_local_register_memory
